// ---- logic/dmx_ctrl.sv ----
// Host controller driving a 256K x 9 DRAM module over its pins
`timescale 1ns/1ps
module dmx_ctrl #(
  parameter int POWERUP_CYCLES = dmx_pkg::POWERUP_CYC,
  parameter int REF_INTERVAL = dmx_pkg::REF_ROW_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Host request port
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [17:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA,
  output logic RSP_PARITY_ERR,
  output logic INIT_DONE,
  output logic MODULE_INSTALLED,
  // Module pins
  output logic [8:0] MUXED_ADDRESS_PINS,
  output logic ROW_STROBE_N,
  output logic COLUMN_STROBE_N,
  output logic PARITY_COLUMN_STROBE_N,
  output logic WRITE_ENABLE_N,
  input wire logic [7:0] SHARED_DATA_LINES_I,
  output logic [7:0] SHARED_DATA_LINES_O,
  output logic SHARED_DATA_LINES_OE,
  output logic PARITY_DATA_IN,
  input wire logic PARITY_DATA_OUT,
  input wire logic MODULE_PRESENT_N
);
  localparam int STEP_W = dmx_pkg::STEP_W;
  localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
  localparam int RI_W = $clog2(REF_INTERVAL + 1);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (POWERUP_CYCLES < 1 || REF_INTERVAL < 64) begin : g_bad_param
    $error("dmx_ctrl: counts too small");
  end

  typedef enum logic [3:0] {
    ST_PAUSE, ST_INIT_RAS, ST_INIT_PRE, ST_IDLE, ST_ROW, ST_COL, ST_CAS,
    ST_REF_RAS, ST_PRE
  } dmx_state_e;

  dmx_state_e state_q;
  logic [STEP_W-1:0] step_q;
  logic [PU_W-1:0] pause_q;
  logic [3:0] init_cnt_q;
  logic [RI_W-1:0] ref_tmr_q;
  logic ref_pend_q;
  logic [7:0] ref_row_q;
  logic wr_q;
  logic [8:0] col_q;
  logic [7:0] wdata_q;

  // Even parity over a byte
  function automatic logic par8(input logic [7:0] b);
    par8 = ^b;
  endfunction

  // Handshake: accept only when idle, initialised and no refresh due
  assign REQ_READY = (state_q == ST_IDLE) && !ref_pend_q; // [RULE18]

  // Presence: pin pulled high externally, low means fitted only
  assign MODULE_INSTALLED = !MODULE_PRESENT_N; // [RULE10] [RULE11]

  // ****************************************
  // Refresh scheduling
  // ****************************************
  // Interval timer raises a pending refresh for one row
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ref_tmr_q <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_tmr_q == RI_W'(REF_INTERVAL - 1)) begin
        ref_tmr_q <= '0;
      end else begin
        ref_tmr_q <= ref_tmr_q + 1'b1;
      end
      if (ref_tmr_q == RI_W'(REF_INTERVAL - 1) && INIT_DONE) begin
        ref_pend_q <= 1'b1; // [RULE2] [RULE18]
      end else if (state_q == ST_REF_RAS && step_q == '0) begin
        ref_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Main sequencer
  // ****************************************
  // Strobe sequencing for init, access and row-only refresh
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_q <= ST_PAUSE;
      step_q <= '0;
      pause_q <= '0;
      init_cnt_q <= '0;
      ref_row_q <= '0;
      wr_q <= 1'b0;
      col_q <= '0;
      wdata_q <= '0;
      INIT_DONE <= 1'b0;
      MUXED_ADDRESS_PINS <= '0;
      ROW_STROBE_N <= 1'b1;
      COLUMN_STROBE_N <= 1'b1;
      PARITY_COLUMN_STROBE_N <= 1'b1;
      WRITE_ENABLE_N <= 1'b1;
      SHARED_DATA_LINES_O <= '0;
      SHARED_DATA_LINES_OE <= 1'b0;
      PARITY_DATA_IN <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      RSP_PARITY_ERR <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_q)
        ST_PAUSE: begin
          pause_q <= pause_q + 1'b1;
          if (pause_q == PU_W'(POWERUP_CYCLES - 1)) begin
            state_q <= ST_INIT_RAS; // [RULE17]
            step_q <= '0;
          end
        end
        ST_INIT_RAS, ST_REF_RAS: begin
          // Row-only cycle, both column strobes held high
          // Row address leads the row strobe by one cycle for setup
          MUXED_ADDRESS_PINS <= {1'b0, ref_row_q}; // [RULE1] [RULE3]
          if (step_q != '0) begin
            ROW_STROBE_N <= 1'b0;
          end
          step_q <= step_q + 1'b1;
          if (step_q == STEP_W'(dmx_pkg::RAS_CYC + 1)) begin
            ROW_STROBE_N <= 1'b1;
            ref_row_q <= ref_row_q + 1'b1; // [RULE2]
            step_q <= '0;
            if (state_q == ST_INIT_RAS) begin
              init_cnt_q <= init_cnt_q + 1'b1;
              state_q <= ST_INIT_PRE;
            end else begin
              state_q <= ST_PRE;
            end
          end
        end
        ST_INIT_PRE: begin
          step_q <= step_q + 1'b1;
          if (step_q == STEP_W'(dmx_pkg::RP_CYC - 1)) begin
            step_q <= '0;
            if (init_cnt_q == 4'(dmx_pkg::INIT_CYCLES)) begin
              state_q <= ST_IDLE; // [RULE17]
              INIT_DONE <= 1'b1;
            end else begin
              state_q <= ST_INIT_RAS;
            end
          end
        end
        ST_IDLE: begin
          if (ref_pend_q) begin
            state_q <= ST_REF_RAS; // [RULE18]
            step_q <= '0;
          end else if (REQ_VALID) begin
            // Row half first, column half kept for later
            MUXED_ADDRESS_PINS <= REQ_ADDR[17:9]; // [RULE1]
            col_q <= REQ_ADDR[8:0];
            wr_q <= REQ_WRITE; // [RULE12]
            wdata_q <= REQ_WDATA;
            state_q <= ST_ROW;
            step_q <= '0;
          end
        end
        ST_ROW: begin
          ROW_STROBE_N <= 1'b0;
          // Early write: write enable low before the column strobe
          WRITE_ENABLE_N <= !wr_q; // [RULE14]
          SHARED_DATA_LINES_O <= wdata_q;
          SHARED_DATA_LINES_OE <= wr_q;
          PARITY_DATA_IN <= par8(wdata_q); // [RULE8]
          step_q <= step_q + 1'b1;
          if (step_q == STEP_W'(dmx_pkg::RAH_CYC)) begin
            MUXED_ADDRESS_PINS <= col_q; // [RULE1]
          end
          if (step_q == STEP_W'(dmx_pkg::RCD_CYC)) begin
            state_q <= ST_COL;
            step_q <= '0;
          end
        end
        ST_COL: begin
          // Both strobes together, one gates eight lines, other the ninth bit
          COLUMN_STROBE_N <= 1'b0; // [RULE6]
          PARITY_COLUMN_STROBE_N <= 1'b0; // [RULE7]
          state_q <= ST_CAS;
          step_q <= '0;
        end
        ST_CAS: begin
          step_q <= step_q + 1'b1;
          if (step_q == STEP_W'(dmx_pkg::CAC_CYC)) begin
            // Sample unlatched data while strobe still low
            if (!wr_q) begin
              RSP_RDATA <= SHARED_DATA_LINES_I; // [RULE5] [RULE15]
              RSP_PARITY_ERR <= par8(SHARED_DATA_LINES_I) != PARITY_DATA_OUT; // [RULE8]
            end else begin
              RSP_PARITY_ERR <= 1'b0; // [RULE13]
            end
            RSP_VALID <= 1'b1;
          end
          if (step_q == STEP_W'(dmx_pkg::RAS_CYC)) begin
            ROW_STROBE_N <= 1'b1;
            COLUMN_STROBE_N <= 1'b1;
            PARITY_COLUMN_STROBE_N <= 1'b1;
            WRITE_ENABLE_N <= 1'b1;
            SHARED_DATA_LINES_OE <= 1'b0;
            state_q <= ST_PRE;
            step_q <= '0;
          end
        end
        ST_PRE: begin
          step_q <= step_q + 1'b1;
          if (step_q == STEP_W'(dmx_pkg::RP_CYC - 1)) begin
            state_q <= ST_IDLE;
            step_q <= '0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- logic/dmx_pkg.sv ----
// Package of constants for the nine-bit DRAM module controller
// Function
// [RULE1] Row then column on shared address pins
// [RULE2] Strobe all 256 rows every refresh period
// [RULE3] Refresh with column strobes held high
// [RULE4] Module latches address and write data
// [RULE5] Read data unlatched, sample while valid
// [RULE6] One column strobe gates eight data lines
// [RULE7] Second column strobe gates ninth bit
// [RULE8] Controller generates and checks parity bit
// [RULE9] Installed module ties presence pin low
// [RULE10] Host pulls presence high, one means absent
// [RULE11] Presence shows installation, not correct function
// [RULE12] Writes and reads may mix freely
// [RULE13] Late-write output levels are invalid data
// [RULE14] Write enable high reads, low writes
// [RULE15] Outputs float until column strobe low
// [RULE16] Column before row refreshes internal counter row
// [RULE17] Power-up pause then eight init cycles
// [RULE18] Counter-driven refresh arbitrated against accesses
package dmx_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_BITS = 9;
  localparam int ROWS = 256;
  localparam int INIT_CYCLES = 8;
  // ****************************************
  // Timing, 100 MHz core clock
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_PERIOD_MS = 4;
  localparam int POWERUP_PAUSE_US = 200;
  localparam int T_RAS_NS = 200;
  localparam int T_RP_NS = 120;
  localparam int T_RCD_NS = 30;
  localparam int T_CAS_NS = 100;
  localparam int T_CAC_NS = 100;
  localparam int T_RAH_NS = 20;
  // Least times round up
  localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAC_CYC = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAH_CYC = (T_RAH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pause rounds up; refresh interval per row is a longest time, rounds down
  localparam int POWERUP_CYC = (POWERUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_ROW_CYC = (REFRESH_PERIOD_MS * 1000000 / ROWS) / CLK_PERIOD_NS;
  // Per-step count width
  localparam int STEP_W = 8;
endpackage

// ---- tb/dmx_ctrl_properties.sv ----
// Concurrent checks on the DRAM module controller ports
`timescale 1ns/1ps
module dmx_ctrl_properties (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Host side
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic INIT_DONE,
  input wire logic MODULE_INSTALLED,
  // Module pins
  input wire logic ROW_STROBE_N,
  input wire logic COLUMN_STROBE_N,
  input wire logic PARITY_COLUMN_STROBE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic [7:0] SHARED_DATA_LINES_O,
  input wire logic SHARED_DATA_LINES_OE,
  input wire logic PARITY_DATA_IN,
  input wire logic MODULE_PRESENT_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Strobe, data and handshake relations
  property p_oe_we; SHARED_DATA_LINES_OE |-> !WRITE_ENABLE_N; endproperty
  a_oe_we: assert property (p_oe_we) else $error("data driven outside write");
  property p_par; !PARITY_COLUMN_STROBE_N && SHARED_DATA_LINES_OE |-> PARITY_DATA_IN == ^SHARED_DATA_LINES_O; endproperty
  a_par: assert property (p_par) else $error("parity bit wrong");
  property p_ras_first; $fell(ROW_STROBE_N) |-> COLUMN_STROBE_N && PARITY_COLUMN_STROBE_N; endproperty
  a_ras_first: assert property (p_ras_first) else $error("column strobe before row");
  property p_cas_in_row; !COLUMN_STROBE_N |-> !ROW_STROBE_N; endproperty
  a_cas_in_row: assert property (p_cas_in_row) else $error("column strobe without row");
  property p_init; !INIT_DONE |-> !REQ_READY && COLUMN_STROBE_N && PARITY_COLUMN_STROBE_N; endproperty
  a_init: assert property (p_init) else $error("access before init");
  property p_ras_low; $fell(ROW_STROBE_N) |-> !ROW_STROBE_N [*8]; endproperty
  a_ras_low: assert property (p_ras_low) else $error("row strobe pulse short");
  // Row strobe falls two edges after the take, response about fifteen later
  property p_take; REQ_VALID && REQ_READY |=> ##1 !ROW_STROBE_N ##[10:30] RSP_VALID; endproperty
  a_take: assert property (p_take) else $error("access not answered");
  property p_pulse; RSP_VALID |=> !RSP_VALID; endproperty
  a_pulse: assert property (p_pulse) else $error("response longer than a cycle");
  property p_present; MODULE_INSTALLED == !MODULE_PRESENT_N; endproperty
  a_present: assert property (p_present) else $error("presence misread");
endmodule
bind dmx_ctrl dmx_ctrl_properties u_props (.CORE_CLK, .RST_B, .REQ_VALID, .REQ_READY, .RSP_VALID, .INIT_DONE,
  .MODULE_INSTALLED, .ROW_STROBE_N, .COLUMN_STROBE_N, .PARITY_COLUMN_STROBE_N, .WRITE_ENABLE_N,
  .SHARED_DATA_LINES_O, .SHARED_DATA_LINES_OE, .PARITY_DATA_IN, .MODULE_PRESENT_N);

// ---- tb/dmx_mem_model.sv ----
// Behavioural model of the nine-bit DRAM module
`timescale 1ns/1ps
module dmx_mem_model (
  // Strobes and address
  input wire logic [8:0] addr,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic parity_column_strobe_n,
  input wire logic we_n,
  // Data and bench controls
  input wire logic [7:0] dq,
  input wire logic d9,
  input wire logic flip,
  input wire logic installed,
  output logic [7:0] dq_out,
  output logic q9,
  output logic present_n
);
  logic [7:0] mem [bit [17:0]];
  logic par [bit [17:0]];
  logic [8:0] row;
  logic [17:0] loc;
  logic [7:0] rd = 8'h00;
  logic rp = 1'b0, ok = 1'b0, ok9 = 1'b0;
  // Row latched only when column strobe is high
  always @(negedge ras_n) if (cas_n) row = addr;
  // Byte lines latch column and data, drive late, float when strobe high
  always @(cas_n) begin
    ok = 1'b0;
    if (cas_n === 1'b0) begin
      loc = {row, addr};
      rd = mem.exists(loc) ? mem[loc] : 8'h00;
      if (!we_n) mem[loc] = dq;
      else #90 ok = !cas_n;
    end
  end
  // Ninth bit on its own strobe
  always @(parity_column_strobe_n) begin
    ok9 = 1'b0;
    if (parity_column_strobe_n === 1'b0) begin
      rp = par.exists({row, addr}) ? par[{row, addr}] : 1'b0;
      if (!we_n) par[{row, addr}] = d9;
      else #90 ok9 = !parity_column_strobe_n;
    end
  end
  // Floating outputs seen as the inverse of the stored value
  assign dq_out = ok ? rd : ~rd;
  assign q9 = ok9 ? rp ^ flip : ~rp;
  assign present_n = !installed;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the nine-bit DRAM module controller
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0, installed = 1'b1, flip = 1'b0;
  logic [17:0] req_addr = 18'h00000;
  logic [7:0] req_wdata = 8'h00, dq_mod, dq_o, rsp_rdata, ras_row;
  logic [8:0] pins;
  logic ras_n, cas_n, parity_column_strobe_n, we_n, oe, d9, q9, present_n, req_ready, rsp_valid, rsp_err, init_done, mod_inst;
  int cas_falls = 0, cas_at_ras = -1;
  logic [31:0] seed = 32'h00000002;
  logic [7:0] sb [bit [17:0]];
  logic [255:0] row_hit = 256'h0;
  int num_errors = 0, tests_run = 0, cycles = 0, ras_only = 0;
  wire [7:0] dq = oe ? dq_o : dq_mod;
  // Clock
  always #5 core_clk = ~core_clk;
  // Design and module model
  dmx_ctrl #(.POWERUP_CYCLES(10), .REF_INTERVAL(200)) u_dut (.CORE_CLK(core_clk), .RST_B(rst_b),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .RSP_PARITY_ERR(rsp_err),
    .INIT_DONE(init_done), .MODULE_INSTALLED(mod_inst), .MUXED_ADDRESS_PINS(pins), .ROW_STROBE_N(ras_n),
    .COLUMN_STROBE_N(cas_n), .PARITY_COLUMN_STROBE_N(parity_column_strobe_n), .WRITE_ENABLE_N(we_n),
    .SHARED_DATA_LINES_I(dq), .SHARED_DATA_LINES_O(dq_o), .SHARED_DATA_LINES_OE(oe),
    .PARITY_DATA_IN(d9), .PARITY_DATA_OUT(q9), .MODULE_PRESENT_N(present_n));
  dmx_mem_model u_mem (.addr(pins), .ras_n(ras_n), .cas_n(cas_n), .parity_column_strobe_n(parity_column_strobe_n), .we_n(we_n), .dq(dq),
    .d9(d9), .flip(flip), .installed(installed), .dq_out(dq_mod), .q9(q9), .present_n(present_n));
  // Rows strobed with no column strobe count as refresh
  always @(negedge ras_n) begin
    ras_row = pins[7:0];
    cas_at_ras = cas_falls;
  end
  always @(negedge cas_n) cas_falls++;
  always @(posedge ras_n) if (cas_falls == cas_at_ras) begin
    ras_only++;
    row_hit[ras_row] = 1'b1;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen_v, exp_v);
    end
  endtask
  // One access: hold request until taken, then judge the response
  task automatic access(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 3000);
    check(req_ready, 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 100);
    check(rsp_valid, 1'b1);
    check(u_mem.loc, a);
    check(rsp_err, !wr && flip);
    if (wr) sb[a] = d;
    else check(rsp_rdata, sb[a]);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    check({ras_n, cas_n, parity_column_strobe_n, oe, init_done, req_ready}, 6'h38);
    rst_b <= 1'b1;
    installed <= 1'b0;
    @(negedge core_clk) check(mod_inst, 1'b0);
    @(posedge core_clk) installed <= 1'b1;
    @(negedge core_clk) check(mod_inst, 1'b1);
    while (init_done !== 1'b1 && cycles < 2000) @(negedge core_clk);
    check(init_done, 1'b1);
    check(ras_only >= 8, 1'b1);
    access(1'b1, 18'h00000, 8'h00);
    access(1'b1, 18'h3FFFF, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      access(1'b1, seed[17:0], seed[25:18]);
      access(1'b0, seed[17:0], 8'h00);
    end
    access(1'b0, 18'h00000, 8'h00);
    flip = 1'b1;
    access(1'b0, 18'h3FFFF, 8'h00);
    flip = 1'b0;
    row_hit = 256'h0;
    repeat (256 * 200 + 400) @(posedge core_clk);
    check(&row_hit, 1'b1);
    tally_and_finish();
  end
endmodule
